// [logic/status_range_cfg.svh]
`ifndef STATUS_RANGE_CFG_SVH
`define STATUS_RANGE_CFG_SVH

// modbus function codes
`define FC_READ_COILS      8'h01
`define FC_READ_HOLDING    8'h03
`define FC_WRITE_MULTIPLE  8'h10
// hart command that returns extended device status
`define CMD_EXT_STATUS     8'h30
// quantities per request
`define STATUS_QTY         16'h0010
`define RANGE_QTY          16'h0002
// configured addresses are one above the slave's own address
`define ADDR_OFFSET        16'h0001
// timing
`define CLK_KHZ            100000
`define POLL_TIME_MS       200
`define RSP_TIMEOUT_MS     100
// reset values
`define STATUS_BYTE_RST    8'h00
`define RANGE_RST          32'h0000_0000

`endif

// [logic/status_range_map.sv]
`timescale 1ns/10ps
`include "status_range_cfg.svh"
// Operation
// - eight device status conditions are one byte, a one bit meaning the condition occurred.
// - a reply to the hart master carries the device status byte as second data byte.
// - the low six bits of extended status byte one flag each variable read, one on fault.
// - extended status bytes two and three hold sixteen status bits from the user slave.
// - status bits one to eight go to byte two and nine to sixteen to byte three, low first.
// - each mapped bit is picked by a selector out of one user status register.
// - the configured status address is one above the real one and is decremented before use.
// - in normal operation the status register is polled periodically with read coils.
// - command 48 from the hart master returns the extended device status.
// - a range origin select chooses local or remote range limits.
// - in remote mode a transfer policy chooses read-and-write or read-only.
// - remote range limits are coded in the slave registers by a configured format.
// - range handling is disabled for a variable not mapped to the primary value.
// - remote read-and-write writes both limits on apply with write multiple registers.
// - remote read-only reads both limits periodically with read holding registers.
module status_range_map
	import status_range_pkg::*;
#(
	parameter int POLL_CYCLES    = `POLL_TIME_MS * `CLK_KHZ,
	parameter int TIMEOUT_CYCLES = `RSP_TIMEOUT_MS * `CLK_KHZ
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// configuration
	input  wire logic        normal_mode_i,
	input  wire logic [15:0] status_addr_i,
	input  wire logic [79:0] bit_select_i,
	input  wire logic        range_origin_select_i,
	input  wire logic        range_transfer_policy_i,
	input  wire logic [1:0]  range_format_i,
	input  wire logic [2:0]  range_var_i,
	input  wire logic [2:0]  pv_var_i,
	input  wire logic [15:0] upper_addr_i,
	input  wire logic [15:0] lower_addr_i,
	input  wire logic [31:0] upper_local_i,
	input  wire logic [31:0] lower_local_i,
	input  wire logic        apply_i,
	// device state
	input  wire logic [7:0]  device_status_i,
	input  wire logic        chan_update_i,
	input  wire logic [5:0]  chan_fault_i,
	// hart slave side
	input  wire logic        hart_cmd_valid_i,
	input  wire logic [7:0]  hart_cmd_i,
	output logic             hart_rsp_valid_o,
	output logic             hart_rsp_ext_o,
	output logic [7:0]       hart_rsp_status_o,
	output logic [7:0]       ext_status0_o,
	output logic [7:0]       ext_status1_o,
	output logic [7:0]       ext_status2_o,
	// modbus master side
	output logic             mb_req_valid_o,
	input  wire logic        mb_req_ready_i,
	output logic [7:0]       mb_func_o,
	output logic [15:0]      mb_addr_o,
	output logic [15:0]      mb_qty_o,
	output logic [31:0]      mb_wdata_o,
	input  wire logic        mb_rsp_valid_i,
	input  wire logic        mb_rsp_ok_i,
	input  wire logic [31:0] mb_rsp_data_i,
	// range limits in use
	output logic [31:0]      range_upper_o,
	output logic [31:0]      range_lower_o,
	output logic             range_active_o
);

	// counts below two would make the tick and the timeout fire at once
	if (POLL_CYCLES < 2 || TIMEOUT_CYCLES < 2) begin : g_bad_counts
		$error("poll and timeout counts must be at least 2");
	end

	// every format is its own inverse, so one function codes and decodes
	function automatic logic [31:0] reorder(input logic [31:0] v,
	                                        input logic [1:0]  f);
		case (range_format_t'(f))
			FMT_1032: reorder = {v[15:0], v[31:16]};
			FMT_3210: reorder = v;
			FMT_0123: reorder = {v[7:0], v[15:8], v[23:16], v[31:24]};
			FMT_2301: reorder = {v[23:16], v[31:24], v[7:0], v[15:8]};
			default:  reorder = v;
		endcase
	endfunction

	poll_state_t state_ff, nxt_state;
	logic [31:0] poll_cnt_ff, nxt_poll_cnt;
	logic [31:0] wait_cnt_ff, nxt_wait_cnt;
	logic        poll_due_ff, nxt_poll_due;
	logic        wr_pend_ff, nxt_wr_pend;
	logic        rng_lower_ff, nxt_rng_lower;
	logic        rng_write_ff, nxt_rng_write;
	logic [15:0] stat_bits_ff, nxt_stat_bits;
	logic [5:0]  chan_ff, nxt_chan;
	logic [31:0] rem_upper_ff, nxt_rem_upper;
	logic [31:0] rem_lower_ff, nxt_rem_lower;
	logic        req_valid_ff, nxt_req_valid;
	logic [7:0]  func_ff, nxt_func;
	logic [15:0] addr_ff, nxt_addr;
	logic [15:0] qty_ff, nxt_qty;
	logic [31:0] wdata_ff, nxt_wdata;
	logic        hart_vld_ff, nxt_hart_vld;
	logic        hart_ext_ff, nxt_hart_ext;
	logic [7:0]  hart_stat_ff, nxt_hart_stat;
	logic [31:0] upper_ff, nxt_upper;
	logic [31:0] lower_ff, nxt_lower;
	logic        active_ff, nxt_active;

	logic        rng_on;
	logic        remote_rd;
	logic        remote_rw;
	logic [15:0] picked;

	// range work exists only for the variable that feeds the primary value
	assign rng_on    = (range_var_i == pv_var_i);
	assign remote_rd = rng_on & range_origin_select_i
	                 & range_transfer_policy_i;
	assign remote_rw = rng_on & range_origin_select_i
	                 & ~range_transfer_policy_i;

	// selector 0 means unused; 1..16 names a bit of the read register
	always_comb begin
		logic [4:0] sel;
		logic [4:0] idx;
		sel = 5'h00;
		idx = 5'h00;
		picked = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			sel = bit_select_i[i*5 +: 5];
			idx = sel - 5'h01;
			if (sel != 5'h00 && sel <= 5'h10)
				picked[i] = mb_rsp_data_i[idx];
		end
	end

	// poll sequencer: pending range write first, else status read, then range read when it applies
	always_comb begin
		nxt_state     = state_ff;
		nxt_poll_cnt  = poll_cnt_ff;
		nxt_wait_cnt  = wait_cnt_ff;
		nxt_poll_due  = poll_due_ff;
		nxt_wr_pend   = wr_pend_ff;
		nxt_rng_lower = rng_lower_ff;
		nxt_rng_write = rng_write_ff;
		nxt_stat_bits = stat_bits_ff;
		nxt_rem_upper = rem_upper_ff;
		nxt_rem_lower = rem_lower_ff;
		nxt_req_valid = req_valid_ff;
		nxt_func      = func_ff;
		nxt_addr      = addr_ff;
		nxt_qty       = qty_ff;
		nxt_wdata     = wdata_ff;

		// periodic tick only runs in normal operation
		if (!normal_mode_i) begin
			nxt_poll_cnt = 32'h0000_0000;
		end else if (poll_cnt_ff >= 32'(POLL_CYCLES - 1)) begin
			nxt_poll_cnt = 32'h0000_0000;
			nxt_poll_due = 1'b1;
		end else begin
			nxt_poll_cnt = poll_cnt_ff + 32'h0000_0001;
		end

		case (state_ff)
			ST_IDLE: begin
				nxt_wait_cnt = 32'h0000_0000;
				if (normal_mode_i && wr_pend_ff && remote_rw) begin
					nxt_wr_pend   = 1'b0;
					nxt_rng_write = 1'b1;
					nxt_rng_lower = 1'b0;
					nxt_req_valid = 1'b1;
					nxt_func      = `FC_WRITE_MULTIPLE;
					nxt_addr      = upper_addr_i - `ADDR_OFFSET;
					nxt_qty       = `RANGE_QTY;
					nxt_wdata     = reorder(upper_local_i,
					                        range_format_i);
					nxt_state     = ST_RNG_REQ;
				end else if (normal_mode_i && poll_due_ff) begin
					nxt_poll_due  = 1'b0;
					nxt_req_valid = 1'b1;
					nxt_func      = `FC_READ_COILS;
					nxt_addr      = status_addr_i - `ADDR_OFFSET;
					nxt_qty       = `STATUS_QTY;
					nxt_state     = ST_STAT_REQ;
				end
			end
			ST_STAT_REQ: begin
				if (mb_req_ready_i) begin
					nxt_req_valid = 1'b0;
					nxt_state     = ST_STAT_WAIT;
				end
			end
			ST_STAT_WAIT: begin
				nxt_wait_cnt = wait_cnt_ff + 32'h0000_0001;
				if (mb_rsp_valid_i) begin
					// a failed read keeps the old bits
					if (mb_rsp_ok_i)
						nxt_stat_bits = picked;
					if (remote_rd) begin
						nxt_rng_write = 1'b0;
						nxt_rng_lower = 1'b0;
						nxt_req_valid = 1'b1;
						nxt_func      = `FC_READ_HOLDING;
						nxt_addr      = upper_addr_i - `ADDR_OFFSET;
						nxt_qty       = `RANGE_QTY;
						nxt_state     = ST_RNG_REQ;
					end else begin
						nxt_state = ST_IDLE;
					end
				end else if (wait_cnt_ff >= 32'(TIMEOUT_CYCLES - 1)) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_RNG_REQ: begin
				nxt_wait_cnt = 32'h0000_0000;
				if (mb_req_ready_i) begin
					nxt_req_valid = 1'b0;
					nxt_state     = ST_RNG_WAIT;
				end
			end
			ST_RNG_WAIT: begin
				nxt_wait_cnt = wait_cnt_ff + 32'h0000_0001;
				if (mb_rsp_valid_i) begin
					if (!rng_write_ff && mb_rsp_ok_i) begin
						if (rng_lower_ff)
							nxt_rem_lower = reorder(mb_rsp_data_i,
							                        range_format_i);
						else
							nxt_rem_upper = reorder(mb_rsp_data_i,
							                        range_format_i);
					end
					if (rng_lower_ff) begin
						nxt_state = ST_IDLE;
					end else begin
						// upper done, lower follows with the same function
						nxt_rng_lower = 1'b1;
						nxt_req_valid = 1'b1;
						nxt_addr      = lower_addr_i - `ADDR_OFFSET;
						nxt_wdata     = reorder(lower_local_i,
						                        range_format_i);
						nxt_state     = ST_RNG_REQ;
					end
				end else if (wait_cnt_ff >= 32'(TIMEOUT_CYCLES - 1)) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state     = ST_IDLE;
				nxt_req_valid = 1'b0;
			end
		endcase

		// apply arriving while the pending flag is taken is not lost
		if (apply_i)
			nxt_wr_pend = 1'b1;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff     <= ST_IDLE;
			poll_cnt_ff  <= 32'h0000_0000;
			wait_cnt_ff  <= 32'h0000_0000;
			poll_due_ff  <= 1'b0;
			wr_pend_ff   <= 1'b0;
			rng_lower_ff <= 1'b0;
			rng_write_ff <= 1'b0;
			stat_bits_ff <= 16'h0000;
			rem_upper_ff <= `RANGE_RST;
			rem_lower_ff <= `RANGE_RST;
			req_valid_ff <= 1'b0;
			func_ff      <= 8'h00;
			addr_ff      <= 16'h0000;
			qty_ff       <= 16'h0000;
			wdata_ff     <= 32'h0000_0000;
		end else begin
			state_ff     <= nxt_state;
			poll_cnt_ff  <= nxt_poll_cnt;
			wait_cnt_ff  <= nxt_wait_cnt;
			poll_due_ff  <= nxt_poll_due;
			wr_pend_ff   <= nxt_wr_pend;
			rng_lower_ff <= nxt_rng_lower;
			rng_write_ff <= nxt_rng_write;
			stat_bits_ff <= nxt_stat_bits;
			rem_upper_ff <= nxt_rem_upper;
			rem_lower_ff <= nxt_rem_lower;
			req_valid_ff <= nxt_req_valid;
			func_ff      <= nxt_func;
			addr_ff      <= nxt_addr;
			qty_ff       <= nxt_qty;
			wdata_ff     <= nxt_wdata;
		end
	end

	// hart answer, channel flags and range limits in use
	always_comb begin
		nxt_chan      = chan_update_i ? chan_fault_i : chan_ff;
		nxt_hart_vld  = hart_cmd_valid_i;
		nxt_hart_ext  = hart_cmd_valid_i
		              && (hart_cmd_i == `CMD_EXT_STATUS);
		nxt_hart_stat = hart_cmd_valid_i ? device_status_i
		                                 : hart_stat_ff;
		nxt_active    = rng_on;
		// remote read-only takes the polled limits, other active cases the local ones; inactive range holds the last limits
		if (remote_rd) begin
			nxt_upper = rem_upper_ff;
			nxt_lower = rem_lower_ff;
		end else if (rng_on) begin
			nxt_upper = upper_local_i;
			nxt_lower = lower_local_i;
		end else begin
			nxt_upper = upper_ff;
			nxt_lower = lower_ff;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			chan_ff      <= 6'h00;
			hart_vld_ff  <= 1'b0;
			hart_ext_ff  <= 1'b0;
			hart_stat_ff <= `STATUS_BYTE_RST;
			upper_ff     <= `RANGE_RST;
			lower_ff     <= `RANGE_RST;
			active_ff    <= 1'b0;
		end else begin
			chan_ff      <= nxt_chan;
			hart_vld_ff  <= nxt_hart_vld;
			hart_ext_ff  <= nxt_hart_ext;
			hart_stat_ff <= nxt_hart_stat;
			upper_ff     <= nxt_upper;
			lower_ff     <= nxt_lower;
			active_ff    <= nxt_active;
		end
	end

	assign hart_rsp_valid_o  = hart_vld_ff;
	assign hart_rsp_ext_o    = hart_ext_ff;
	assign hart_rsp_status_o = hart_stat_ff;
	assign ext_status0_o     = {2'b00, chan_ff};
	assign ext_status1_o     = stat_bits_ff[7:0];
	assign ext_status2_o     = stat_bits_ff[15:8];
	assign mb_req_valid_o    = req_valid_ff;
	assign mb_func_o         = func_ff;
	assign mb_addr_o         = addr_ff;
	assign mb_qty_o          = qty_ff;
	assign mb_wdata_o        = wdata_ff;
	assign range_upper_o     = upper_ff;
	assign range_lower_o     = lower_ff;
	assign range_active_o    = active_ff;

endmodule

// [logic/status_range_pkg.sv]
package status_range_pkg;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_STAT_REQ  = 3'b001,
		ST_STAT_WAIT = 3'b010,
		ST_RNG_REQ   = 3'b011,
		ST_RNG_WAIT  = 3'b100
	} poll_state_t;

	// register storage format of a 32-bit float in two slave registers
	typedef enum logic [1:0] {
		FMT_1032 = 2'b00,
		FMT_3210 = 2'b01,
		FMT_0123 = 2'b10,
		FMT_2301 = 2'b11
	} range_format_t;

endpackage

// [testbench/mb_slave_model.sv]
`timescale 1ns/10ps
`include "status_range_cfg.svh"
// user slave: one request at a time, prompt or slow on demand
module mb_slave_model #(
	parameter logic [15:0] UPPER_REAL = 16'h9C40
) (
	input  wire logic        clock_i,
	input  wire logic        slow_i,
	input  wire logic [15:0] coils_i,
	input  wire logic [31:0] upper_i,
	input  wire logic [31:0] lower_i,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  func_i,
	input  wire logic [15:0] addr_i,
	output logic             ready_o,
	output logic             rsp_valid_o,
	output logic             rsp_ok_o,
	output logic [31:0]      rsp_data_o
);
	logic [7:0]  f;
	logic [15:0] a;
	// data goes to the inverse after each answer so stale reads show up
	always begin
		@(posedge clock_i);
		if (req_valid_i) begin
			f = func_i;
			a = addr_i;
			repeat (slow_i ? 3 : 0) @(posedge clock_i);
			ready_o <= 1'h1;
			@(posedge clock_i);
			ready_o <= 1'h0;
			repeat (slow_i ? 5 : 1) @(posedge clock_i);
			if (f == `FC_READ_COILS)
				rsp_data_o <= {16'h0000, coils_i};
			else
				rsp_data_o <= (a == UPPER_REAL) ? upper_i : lower_i;
			rsp_valid_o <= 1'h1;
			@(posedge clock_i);
			rsp_valid_o <= 1'h0;
			rsp_data_o <= ~rsp_data_o;
		end
	end
	initial begin
		{ready_o, rsp_valid_o} = 2'h0;
		rsp_ok_o = 1'h1;
		rsp_data_o = 32'h5A5A_5A5A;
	end
endmodule

// [testbench/status_range_map_assertions.sv]
`timescale 1ns/10ps
`include "status_range_cfg.svh"
// watches the gateway ports only; one clock, one reset
module status_range_map_assertions (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        hart_cmd_valid_i,
	input  wire logic [7:0]  hart_cmd_i,
	input  wire logic [7:0]  device_status_i,
	input  wire logic        chan_update_i,
	input  wire logic [5:0]  chan_fault_i,
	input  wire logic [15:0] status_addr_i,
	input  wire logic [15:0] upper_addr_i,
	input  wire logic [15:0] lower_addr_i,
	input  wire logic        range_origin_select_i,
	input  wire logic [2:0]  range_var_i,
	input  wire logic [2:0]  pv_var_i,
	input  wire logic [31:0] upper_local_i,
	input  wire logic        mb_req_ready_i,
	input  wire logic        mb_rsp_valid_i,
	input  wire logic        hart_rsp_valid_o,
	input  wire logic        hart_rsp_ext_o,
	input  wire logic [7:0]  hart_rsp_status_o,
	input  wire logic [7:0]  ext_status0_o,
	input  wire logic [7:0]  ext_status1_o,
	input  wire logic [7:0]  ext_status2_o,
	input  wire logic        mb_req_valid_o,
	input  wire logic [7:0]  mb_func_o,
	input  wire logic [15:0] mb_addr_o,
	input  wire logic [15:0] mb_qty_o,
	input  wire logic [31:0] mb_wdata_o,
	input  wire logic [31:0] range_upper_o,
	input  wire logic        range_active_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_hart_rsp; hart_rsp_valid_o == $past(hart_cmd_valid_i);
	endproperty
	a_hart_rsp: assert property (p_hart_rsp)
		else $error("hart reply pulse misplaced");
	property p_hart_ext;
		hart_rsp_ext_o == $past(hart_cmd_valid_i && hart_cmd_i == `CMD_EXT_STATUS);
	endproperty
	a_hart_ext: assert property (p_hart_ext)
		else $error("extended status flag wrong");
	property p_hart_stat;
		hart_cmd_valid_i |=> hart_rsp_status_o == $past(device_status_i);
	endproperty
	a_hart_stat: assert property (p_hart_stat)
		else $error("status byte in reply wrong");
	property p_chan;
		chan_update_i |=> ext_status0_o == {2'h0, $past(chan_fault_i)};
	endproperty
	a_chan: assert property (p_chan)
		else $error("channel flags wrong");
	property p_hold;
		!mb_rsp_valid_i |=> $stable({ext_status1_o, ext_status2_o});
	endproperty
	a_hold: assert property (p_hold)
		else $error("status bits changed without an answer");
	property p_stat_req; mb_req_valid_o && mb_func_o == `FC_READ_COILS |->
		mb_addr_o == status_addr_i - `ADDR_OFFSET && mb_qty_o == `STATUS_QTY;
	endproperty
	a_stat_req: assert property (p_stat_req)
		else $error("status poll address or quantity wrong");
	property p_stand; mb_req_valid_o && !mb_req_ready_i |=>
		mb_req_valid_o && $stable({mb_func_o, mb_addr_o, mb_wdata_o});
	endproperty
	a_stand: assert property (p_stand)
		else $error("request changed before taken");
	property p_taken; mb_req_valid_o && mb_req_ready_i |=> !mb_req_valid_o;
	endproperty
	a_taken: assert property (p_taken)
		else $error("request held after taken");
	property p_write; mb_req_valid_o && mb_func_o == `FC_WRITE_MULTIPLE |->
		mb_qty_o == `RANGE_QTY && (mb_addr_o == upper_addr_i - `ADDR_OFFSET ||
		mb_addr_o == lower_addr_i - `ADDR_OFFSET);
	endproperty
	a_write: assert property (p_write)
		else $error("range write malformed");
	// the first edge after reset still shows the reset value of the flag
	property p_active; !$past(rst_i) |->
		range_active_o == $past(range_var_i == pv_var_i);
	endproperty
	a_active: assert property (p_active)
		else $error("range active flag wrong");
	property p_local; !rst_i && range_var_i == pv_var_i
		&& !range_origin_select_i |=> range_upper_o == $past(upper_local_i);
	endproperty
	a_local: assert property (p_local)
		else $error("local upper limit not in use");
	c_ext: cover property (hart_rsp_ext_o);
	c_write: cover property (mb_req_valid_o && mb_func_o == `FC_WRITE_MULTIPLE);
	c_read: cover property (mb_req_valid_o && mb_func_o == `FC_READ_HOLDING);
endmodule

// [testbench/test_status_range_map.sv]
`timescale 1ns/10ps
`include "status_range_cfg.svh"
module test_status_range_map;
	logic        clock_i, rst_i, normal_mode_i, apply_i, chan_update_i;
	logic        range_origin_select_i, range_transfer_policy_i, slow;
	logic        hart_cmd_valid_i, mb_req_ready_i, mb_rsp_valid_i;
	logic        mb_rsp_ok_i, hart_rsp_valid_o, hart_rsp_ext_o;
	logic        mb_req_valid_o, range_active_o;
	logic [1:0]  range_format_i;
	logic [2:0]  range_var_i, pv_var_i;
	logic [5:0]  chan_fault_i;
	logic [7:0]  device_status_i, hart_cmd_i, hart_rsp_status_o, mb_func_o;
	logic [7:0]  ext_status0_o, ext_status1_o, ext_status2_o;
	logic [15:0] status_addr_i, upper_addr_i, lower_addr_i, coils;
	logic [15:0] mb_addr_o, mb_qty_o;
	logic [31:0] upper_local_i, lower_local_i, mb_rsp_data_i, mb_wdata_o;
	logic [31:0] range_upper_o, range_lower_o, up_reg, lo_reg, wd;
	logic [79:0] bit_select_i;
	int          error_cnt, comparisons;

	status_range_map #(.POLL_CYCLES(50), .TIMEOUT_CYCLES(40)) uut (.*);
	mb_slave_model #(.UPPER_REAL(16'h9C40)) u_slave (.clock_i(clock_i),
		.slow_i(slow), .coils_i(coils), .upper_i(up_reg), .lower_i(lo_reg),
		.req_valid_i(mb_req_valid_o), .func_i(mb_func_o),
		.addr_i(mb_addr_o), .ready_o(mb_req_ready_i),
		.rsp_valid_o(mb_rsp_valid_i), .rsp_ok_o(mb_rsp_ok_i),
		.rsp_data_o(mb_rsp_data_i));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one hart command, reply looked at in its single cycle
	task hart(input logic [7:0] c);
		@(posedge clock_i);
		hart_cmd_valid_i <= 1'h1;
		hart_cmd_i <= c;
		@(posedge clock_i);
		hart_cmd_valid_i <= 1'h0;
		#1;
		chk("rsp_valid", 32'h1, hart_rsp_valid_o);
		chk("rsp_ext", c == 8'h30, hart_rsp_ext_o);
		chk("rsp_status", 32'h96, hart_rsp_status_o);
	endtask
	// bounded wait for a taken request of one function and its answer
	task wait_func(input logic [7:0] f);
		int n;
		n = 0;
		@(posedge clock_i);
		while (!(mb_req_valid_o && mb_req_ready_i && mb_func_o === f)
			&& n < 400) begin
			@(posedge clock_i);
			n++;
		end
		wd = mb_wdata_o;
		while (mb_rsp_valid_i !== 1'h1 && n < 400) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 400)
			chk("handshake", 32'h1, 32'h0);
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	initial begin
		clock_i = 1'h0;
		forever #5 clock_i = ~clock_i;
	end
	// cut a hang short; the whole run needs well under this
	initial begin
		#200us;
		chk("watchdog", 32'h0, 32'h1);
		end_sim;
	end
	initial begin
		{normal_mode_i, apply_i, chan_update_i, hart_cmd_valid_i} = 4'h0;
		{range_origin_select_i, range_transfer_policy_i, slow} = 3'h0;
		{range_format_i, range_var_i, pv_var_i, chan_fault_i} = 14'h0;
		{error_cnt, comparisons} = 64'h0;
		rst_i = 1'h1;
		hart_cmd_i = 8'h00;
		device_status_i = 8'h96;
		{status_addr_i, upper_addr_i, lower_addr_i} = 48'h2711_9C41_C351;
		{upper_local_i, lower_local_i} = 64'h1122_3344_5566_7788;
		{coils, up_reg, lo_reg} = 80'hA5C3_AABB_CCDD_0102_0304;
		// identity selectors, except bit 1 takes slave bit 15 and bit 2 none
		for (int i = 0; i < 16; i++)
			bit_select_i[5*i +: 5] = 5'(i + 1);
		bit_select_i[9:0] = 10'h010;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'h0;
		@(posedge clock_i);
		#1;
		chk("ext_status1", 32'h0, ext_status1_o);
		hart(8'h30);
		hart(8'h03);
		@(posedge clock_i);
		chan_fault_i <= 6'h2A;
		chan_update_i <= 1'h1;
		@(posedge clock_i);
		chan_update_i <= 1'h0;
		chan_fault_i <= 6'h15;
		normal_mode_i <= 1'h1;
		#1;
		chk("ext_status0", 32'h2A, ext_status0_o);
		wait_func(`FC_READ_COILS);
		chk("ext_status1", 32'hC1, ext_status1_o);
		chk("ext_status2", 32'hA5, ext_status2_o);
		chk("ext_status0", 32'h2A, ext_status0_o);
		chk("upper_local", 32'h1122_3344, range_upper_o);
		@(posedge clock_i);
		range_var_i <= 3'h1;
		upper_local_i <= 32'h0;
		repeat (3) @(posedge clock_i);
		#1;
		chk("upper_hold", 32'h1122_3344, range_upper_o);
		chk("active", 32'h0, range_active_o);
		@(posedge clock_i);
		{range_var_i, range_origin_select_i, range_transfer_policy_i} <= 5'h3;
		slow <= 1'h1;
		wait_func(`FC_READ_HOLDING);
		wait_func(`FC_READ_HOLDING);
		chk("upper_remote", 32'hCCDD_AABB, range_upper_o);
		chk("lower_remote", 32'h0304_0102, range_lower_o);
		@(posedge clock_i);
		range_transfer_policy_i <= 1'h0;
		upper_local_i <= 32'h1122_3344;
		apply_i <= 1'h1;
		@(posedge clock_i);
		apply_i <= 1'h0;
		wait_func(`FC_WRITE_MULTIPLE);
		chk("write_upper", 32'h3344_1122, wd);
		wait_func(`FC_WRITE_MULTIPLE);
		chk("write_lower", 32'h7788_5566, wd);
		end_sim;
	end
endmodule

bind status_range_map status_range_map_assertions u_chk (.*);
